/* File: hw/ccs_consts.svh */
// Constants for the complement conversion sequencer
`ifndef CCS_CONSTS_SVH
`define CCS_CONSTS_SVH

// ----------------------------------------------------------------
// Counter group geometry
// ----------------------------------------------------------------
`define CCS_DIGITS 6
`define CCS_DIGIT_W 4
`define CCS_HIGH_POS 5

// ----------------------------------------------------------------
// Digit arithmetic
// ----------------------------------------------------------------
`define CCS_NINE 4'h9
`define CCS_TEN 5'h0a
// Emitter spot for digit d is (9 - 2d) mod 10, formed as 19 - 2d
`define CCS_EMIT_BASE 5'h13

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CCS_DIGIT_RESET 4'h0

`endif

/* File: hw/ccs_pkg.sv */
// Types shared by the complement conversion sequencer modules
package ccs_pkg;

    // ----------------------------------------------------------------
    // Sequencer states, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        CCS_IDLE    = 5'b0_0001,
        CCS_TEST    = 5'b0_0010,
        CCS_CONVERT = 5'b0_0100,
        CCS_RESTART = 5'b0_1000,
        CCS_TOTAL   = 5'b1_0000
    } ccs_state_t;

    typedef struct packed {
        ccs_state_t phase;
        logic minorHoldA;
        logic programChangeHold;
        logic convertRelayGroup;
        logic negativeConvertRelay;
        logic conversionTrigger;
        logic conversionDoneLatch;
        logic minorRestartRelay;
        logic totalRestartRelay;
        logic negativeBalanceRelay;
        logic minorProgramLevel;
        logic conversionActive;
    } ccs_seq_t;

    typedef struct packed {
        logic [3:0] digit;
        logic startMagnet;
        logic fired;
    } ccs_pos_t;

    typedef struct packed {
        logic creditSymbol;
        logic camSeen;
        logic entryMade;
    } ccs_credit_t;

endpackage : ccs_pkg

/* File: hw/ccs_digit_position.sv */
// One counter wheel position with its conversion emitter and start magnet
`include "ccs_consts.svh"

module ccs_digit_position (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic load,
    input wire logic [`CCS_DIGIT_W-1:0] loadValue,
    input wire logic convertActive,
    input wire logic digitStrobe,
    input wire logic [`CCS_DIGIT_W-1:0] digitTime,
    output logic [`CCS_DIGIT_W-1:0] digit,
    output logic startMagnet
);
    import ccs_pkg::*;

    ccs_pos_t r;
    ccs_pos_t next_r;

    // Spot on which the emitter brush rests for a stored digit
    function automatic logic [3:0] emitterSpot(input logic [3:0] d);
        logic [4:0] t;
        t = `CCS_EMIT_BASE - {d, 1'b0};
        if (t >= `CCS_TEN) begin
            t = t - `CCS_TEN;
        end
        return t[3:0];
    endfunction : emitterSpot

    always_comb begin
        logic [4:0] sum;
        sum = 5'h00;
        next_r = r;
        next_r.startMagnet = 1'b0;
        // The spot follows the moving wheel, so each wheel may fire only once per window
        if (!convertActive) begin
            next_r.fired = 1'b0;
        end
        if (load) begin
            next_r.digit = loadValue;
        end else if (convertActive && !r.fired && digitStrobe && digitTime == emitterSpot(r.digit)) begin
            // Wheel advances by the impulse time, no carry between wheels
            next_r.startMagnet = 1'b1;
            next_r.fired = 1'b1;
            sum = {1'b0, r.digit} + {1'b0, digitTime};
            if (sum >= `CCS_TEN) begin
                sum = sum - `CCS_TEN;
            end
            next_r.digit = sum[3:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign digit = r.digit;
    assign startMagnet = r.startMagnet;

endmodule : ccs_digit_position

/* File: hw/ccs_credit_symbol.sv */
// Credit symbol exit impulse for subtract and credit total cycles
module ccs_credit_symbol (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cardFeedCycle,
    input wire logic subtractEntry,
    input wire logic addEntry,
    input wire logic creditCam,
    input wire logic totalCycle,
    input wire logic negativeBalance,
    input wire logic totalCycleEnd,
    output logic creditSymbol
);
    import ccs_pkg::*;

    ccs_credit_t r;
    ccs_credit_t next_r;

    always_comb begin
        logic camRise;
        camRise = creditCam && !r.camSeen;
        next_r = r;
        next_r.camSeen = creditCam;
        next_r.creditSymbol = 1'b0;
        // Entry seen wins over the clear at total end
        if (totalCycleEnd) begin
            next_r.entryMade = 1'b0;
        end
        if (cardFeedCycle && (addEntry || subtractEntry)) begin
            next_r.entryMade = 1'b1;
        end
        if (camRise && cardFeedCycle && subtractEntry) begin
            next_r.creditSymbol = 1'b1;
        end
        // An untouched zero counter is not a credit balance
        if (camRise && totalCycle && negativeBalance && r.entryMade) begin
            next_r.creditSymbol = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign creditSymbol = r.creditSymbol;

endmodule : ccs_credit_symbol

/* File: hw/ccs_sequencer.sv */
// Conversion cycle sequencer for a net-balance accumulating counter
`include "ccs_consts.svh"

// Behaviour
// - The first minor-program hold relays stay energized for the whole conversion cycle via a bypass.
// - The program-change hold relay stays energized during conversion via a contact shunting its cam hold.
// - Convert relays energize from trigger and late all-cycles timing, never latch, and drop with it.
// - The negative convert relay energizes from the negative-balance test in the same window, unheld.
// - Each position's start magnet fires at the digit time picked by its emitter brush spot.
// - After conversion the counter holds the true figure instead of the complement.
// - The done latch sets from trigger plus latch-pick cam and holds through the hold cam breaker.
// - While the done latch is set the trigger cannot energize again.
// - The minor restart relay energizes through minor hold once the trigger drops.
// - The total restart relay energizes through program-change hold once the trigger drops.
// - Minor program level outputs come on again after conversion for the remaining total cycle.
// - One credit impulse is emitted per card-feed cycle in which the counter subtracts.
// - A credit impulse is also given in credit total cycles via total and negative-balance relays.
// - No credit symbol is given for a zero balance with no add or subtract entry.
module ccs_sequencer (
    input wire logic clk,
    input wire logic reset_n,
    // Counter group entries
    input wire logic counterLoad,
    input wire logic [`CCS_DIGITS*`CCS_DIGIT_W-1:0] counterLoadValue,
    input wire logic cardFeedCycle,
    input wire logic addEntry,
    input wire logic subtractEntry,
    // Cycle timing cams
    input wire logic digitStrobe,
    input wire logic [`CCS_DIGIT_W-1:0] digitTime,
    input wire logic lateAllCycles,
    input wire logic latchPickCam,
    input wire logic hold_cam_breaker,
    input wire logic creditCam,
    input wire logic cycleEnd,
    // Program wiring
    input wire logic totalProgramStart,
    input wire logic negativeTestWired,
    // Relay and hub outputs
    output logic minor_hold_a,
    output logic program_change_hold,
    output logic convert_relay_group,
    output logic negative_convert_relay,
    output logic conversion_trigger,
    output logic conversion_done_latch,
    output logic minor_restart_relay,
    output logic total_restart_relay,
    output logic negative_balance_relay,
    output logic minorProgramLevel,
    output logic credit_symbol,
    output logic [`CCS_DIGITS-1:0] startMagnet,
    output logic [`CCS_DIGITS*`CCS_DIGIT_W-1:0] counterValue
);
    import ccs_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    ccs_seq_t r;
    ccs_seq_t next_r;

    logic [`CCS_DIGITS*`CCS_DIGIT_W-1:0] digits;
    logic highOrderNine;
    logic convertWindow;
    logic totalCycle;
    logic totalEnd;

    assign highOrderNine = digits[`CCS_HIGH_POS*`CCS_DIGIT_W +: `CCS_DIGIT_W] == `CCS_NINE;
    assign totalCycle = r.phase == CCS_TOTAL;
    assign totalEnd = totalCycle && cycleEnd;
    // Start magnets only see impulses while the convert relays are up
    assign convertWindow = r.convertRelayGroup;

    // ----------------------------------------------------------------
    // Counter positions
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `CCS_DIGITS; g = g + 1) begin : gPos
            ccs_digit_position uPos (
                .clk(clk),
                .reset_n(reset_n),
                .load(counterLoad),
                .loadValue(counterLoadValue[g*`CCS_DIGIT_W +: `CCS_DIGIT_W]),
                .convertActive(convertWindow),
                .digitStrobe(digitStrobe),
                .digitTime(digitTime),
                .digit(digits[g*`CCS_DIGIT_W +: `CCS_DIGIT_W]),
                .startMagnet(startMagnet[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Credit symbol exit
    // ----------------------------------------------------------------
    ccs_credit_symbol uCredit (
        .clk(clk),
        .reset_n(reset_n),
        .cardFeedCycle(cardFeedCycle),
        .subtractEntry(subtractEntry),
        .addEntry(addEntry),
        .creditCam(creditCam),
        .totalCycle(totalCycle),
        .negativeBalance(r.negativeBalanceRelay),
        .totalCycleEnd(totalEnd),
        .creditSymbol(credit_symbol)
    );

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.minorRestartRelay = 1'b0;
        next_r.totalRestartRelay = 1'b0;

        // Relays picked from the late all-cycles impulse carry no hold
        next_r.convertRelayGroup = r.conversionTrigger && lateAllCycles;
        next_r.negativeConvertRelay = r.negativeBalanceRelay && r.conversionActive
            && lateAllCycles;

        // Latch holds on its own contact through the hold cam, or while the total runs
        if (r.conversionTrigger && latchPickCam) begin
            next_r.conversionDoneLatch = 1'b1;
        end else if (totalEnd) begin
            next_r.conversionDoneLatch = 1'b0;
        end else if (!(hold_cam_breaker || r.phase != CCS_IDLE)) begin
            next_r.conversionDoneLatch = 1'b0;
        end

        unique case (r.phase)
            CCS_IDLE: begin
                if (totalProgramStart) begin
                    next_r.minorHoldA = 1'b1;
                    next_r.programChangeHold = 1'b1;
                    next_r.phase = CCS_TEST;
                end
            end
            CCS_TEST: begin
                // Nine in the high-order wheel marks a stored complement
                next_r.negativeBalanceRelay = negativeTestWired && highOrderNine;
                if (negativeTestWired && highOrderNine && !r.conversionDoneLatch) begin
                    next_r.conversionTrigger = 1'b1;
                    next_r.conversionActive = 1'b1;
                    next_r.phase = CCS_CONVERT;
                end else begin
                    next_r.minorProgramLevel = 1'b1;
                    next_r.phase = CCS_TOTAL;
                end
            end
            CCS_CONVERT: begin
                // Bypass keeps the hold relays up past their cam breakers
                next_r.minorHoldA = 1'b1;
                next_r.programChangeHold = 1'b1;
                if (cycleEnd) begin
                    next_r.conversionTrigger = 1'b0;
                    next_r.conversionActive = 1'b0;
                    next_r.phase = CCS_RESTART;
                end
            end
            CCS_RESTART: begin
                // Trigger contact is back on its closed side here
                next_r.minorRestartRelay = r.minorHoldA;
                next_r.totalRestartRelay = r.programChangeHold;
                next_r.minorProgramLevel = 1'b1;
                next_r.phase = CCS_TOTAL;
            end
            CCS_TOTAL: begin
                if (cycleEnd) begin
                    next_r.minorHoldA = 1'b0;
                    next_r.programChangeHold = 1'b0;
                    next_r.minorProgramLevel = 1'b0;
                    next_r.negativeBalanceRelay = 1'b0;
                    next_r.phase = CCS_IDLE;
                end
            end
            default: begin
                next_r = '0;
                next_r.phase = CCS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
            r.phase <= CCS_IDLE;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign minor_hold_a = r.minorHoldA;
    assign program_change_hold = r.programChangeHold;
    assign convert_relay_group = r.convertRelayGroup;
    assign negative_convert_relay = r.negativeConvertRelay;
    assign conversion_trigger = r.conversionTrigger;
    assign conversion_done_latch = r.conversionDoneLatch;
    assign minor_restart_relay = r.minorRestartRelay;
    assign total_restart_relay = r.totalRestartRelay;
    assign negative_balance_relay = r.negativeBalanceRelay;
    assign minorProgramLevel = r.minorProgramLevel;
    assign counterValue = digits;

endmodule : ccs_sequencer

/* File: tb/ccs_sequencer_sva.sv */
// Concurrent checks on the conversion sequencer ports
module ccs_sequencer_sva (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic digitStrobe,
    input wire logic lateAllCycles,
    input wire logic latchPickCam,
    input wire logic negativeTestWired,
    input wire logic minor_hold_a,
    input wire logic program_change_hold,
    input wire logic convert_relay_group,
    input wire logic negative_convert_relay,
    input wire logic conversion_trigger,
    input wire logic conversion_done_latch,
    input wire logic minor_restart_relay,
    input wire logic total_restart_relay,
    input wire logic negative_balance_relay,
    input wire logic minorProgramLevel,
    input wire logic [5:0] startMagnet,
    input wire logic [23:0] counterValue
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    AST_HOLDS: assert property (conversion_trigger |-> minor_hold_a && program_change_hold)
        else $error("hold relays dropped in conversion");
    AST_CONV_PICK: assert property (conversion_trigger && lateAllCycles |=> convert_relay_group)
        else $error("convert relays not picked");
    AST_CONV_DROP: assert property (!lateAllCycles |=> !convert_relay_group)
        else $error("convert relays held past window");
    AST_NEG_CONV: assert property (conversion_trigger && lateAllCycles |=>
        negative_convert_relay == $past(negative_balance_relay))
        else $error("negative convert relay wrong");
    AST_MAGNET: assert property (startMagnet != 6'h00 |-> $past(convert_relay_group) && $past(digitStrobe))
        else $error("start magnet outside digit time");
    AST_MAGNET_ADDS: assert property (startMagnet[0] |->
        counterValue[3:0] == 4'h9 - $past(counterValue[3:0]))
        else $error("units wheel not converted");
    AST_LATCH_SET: assert property (conversion_trigger && latchPickCam |=> conversion_done_latch)
        else $error("done latch not set");
    AST_NO_REPICK: assert property ($rose(conversion_trigger) |-> !$past(conversion_done_latch))
        else $error("trigger repicked with latch set");
    AST_RESTART: assert property ($fell(conversion_trigger) |=> minor_restart_relay && total_restart_relay)
        else $error("restart relays missing");
    AST_LEVEL_AGAIN: assert property (minor_restart_relay |-> minorProgramLevel ##1 minorProgramLevel)
        else $error("minor level not restored");
    AST_NINE_ONLY: assert property ($rose(conversion_trigger) |->
        counterValue[23:20] == 4'h9 && negativeTestWired)
        else $error("conversion without negative test");
    AST_LATCH_CLEAR: assert property ($fell(minorProgramLevel) |-> !conversion_done_latch)
        else $error("done latch left set after total");
endmodule : ccs_sequencer_sva

bind ccs_sequencer ccs_sequencer_sva ccs_sequencer_sva_i (.clk, .reset_n, .digitStrobe, .lateAllCycles,
    .latchPickCam, .negativeTestWired, .minor_hold_a, .program_change_hold, .convert_relay_group,
    .negative_convert_relay, .conversion_trigger, .conversion_done_latch, .minor_restart_relay,
    .total_restart_relay, .negative_balance_relay, .minorProgramLevel, .startMagnet, .counterValue);

/* File: tb/ccs_cam_model.sv */
// Machine-cycle cam breaker and digit emitter model
module ccs_cam_model (
    input wire logic clk,
    input wire logic reset_n,
    output logic digitStrobe,
    output logic [3:0] digitTime,
    output logic lateAllCycles,
    output logic latchPickCam,
    output logic hold_cam_breaker,
    output logic creditCam,
    output logic cycleEnd
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] pos;

    // 32 clocks a machine cycle; digit times 9 down to 0 on even spots
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pos <= 5'h00;
        end else begin
            pos <= pos + 5'h01;
        end
    end
    assign digitStrobe = (pos >= 5'h06) && (pos <= 5'h18) && !pos[0];
    // The value steps every second clock, so the odd spot after each strobe still shows that strobe's digit time
    assign digitTime = 4'hc - pos[4:1];
    assign lateAllCycles = (pos >= 5'h04) && (pos <= 5'h19);
    assign latchPickCam = (pos[4:1] == 4'hd);
    assign creditCam = (pos[4:1] == 4'he);
    assign hold_cam_breaker = (pos > 5'h01);
    assign cycleEnd = (pos == 5'h1f);
endmodule : ccs_cam_model

/* File: tb/ccs_sequencer_tb.sv */
// Self-checking bench for the complement conversion sequencer
module ccs_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic counterLoad = 1'b0, cardFeedCycle = 1'b0, addEntry = 1'b0, subtractEntry = 1'b0;
    logic totalProgramStart = 1'b0, negativeTestWired = 1'b0;
    logic [23:0] counterLoadValue = 24'h00_0000;
    logic digitStrobe, lateAllCycles, latchPickCam, hold_cam_breaker, creditCam, cycleEnd;
    logic [3:0] digitTime;
    logic minor_hold_a, program_change_hold, convert_relay_group, negative_convert_relay;
    logic conversion_trigger, conversion_done_latch, minor_restart_relay, total_restart_relay;
    logic negative_balance_relay, minorProgramLevel, credit_symbol;
    logic [5:0] startMagnet;
    logic [23:0] counterValue;
    logic [24:0] notes[$];
    int fails = 0, cmp_count = 0, seed = 87;

    ccs_cam_model ccs_cam_model_i (.clk, .reset_n, .digitStrobe, .digitTime, .lateAllCycles,
        .latchPickCam, .hold_cam_breaker, .creditCam, .cycleEnd);
    ccs_sequencer ccs_sequencer_i (.clk, .reset_n, .counterLoad, .counterLoadValue, .cardFeedCycle,
        .addEntry, .subtractEntry, .digitStrobe, .digitTime, .lateAllCycles, .latchPickCam,
        .hold_cam_breaker, .creditCam, .cycleEnd, .totalProgramStart, .negativeTestWired,
        .minor_hold_a, .program_change_hold, .convert_relay_group, .negative_convert_relay,
        .conversion_trigger, .conversion_done_latch, .minor_restart_relay, .total_restart_relay,
        .negative_balance_relay, .minorProgramLevel, .credit_symbol, .startMagnet, .counterValue);

    initial begin
        forever #10 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Scoreboard: top bit of a note marks a credit impulse
    // ----------------------------------------------------------------
    task automatic take(input logic [24:0] got);
        logic [24:0] exp;
        exp = 25'h1ff_ffff;
        if (notes.size() != 0) begin
            exp = notes.pop_front();
        end
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : take

    task automatic cmp_conv(input logic [23:0] got);
        take({1'b0, got});
    endtask : cmp_conv

    task automatic cmp_credit();
        take(25'h100_0000);
    endtask : cmp_credit

    // Pulses stand one clock, so the falling edge sees each exactly once
    always @(negedge clk) begin
        if (minor_restart_relay === 1'b1) begin
            cmp_conv(counterValue);
        end
        if (credit_symbol === 1'b1) begin
            cmp_credit();
        end
    end

    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    // Cycle end is looked at mid-cycle, where it has settled, and the task returns on the edge ending it
    task automatic sync();
        int n;
        logic seen;
        n = 0;
        seen = 1'b0;
        while (!seen && n < 100) begin
            @(negedge clk);
            seen = (cycleEnd === 1'b1);
            @(posedge clk);
            n++;
        end
        if (!seen) begin
            fails++;
            $display("Error at %0t: machine cycle end not seen", $time);
        end
    endtask : sync

    task automatic card(input logic sub, input logic add);
        sync();
        cardFeedCycle <= 1'b1;
        subtractEntry <= sub;
        addEntry <= add;
        if (sub) begin
            notes.push_back(25'h100_0000);
        end
        sync();
        cardFeedCycle <= 1'b0;
        subtractEntry <= 1'b0;
        addEntry <= 1'b0;
        $display("card cycle done sub=%0b add=%0b", sub, add);
    endtask : card

    task automatic total(input logic [23:0] v, input logic wired, input logic credit);
        logic conv;
        logic [23:0] t;
        conv = wired && (v[23:20] == 4'h9);
        for (int i = 0; i < 6; i++) begin
            t[4*i +: 4] = 4'h9 - v[4*i +: 4];
        end
        @(posedge clk);
        counterLoad <= 1'b1;
        counterLoadValue <= v;
        negativeTestWired <= wired;
        @(posedge clk);
        counterLoad <= 1'b0;
        if (conv) begin
            notes.push_back({1'b0, t});
        end
        if (credit) begin
            notes.push_back(25'h100_0000);
        end
        sync();
        totalProgramStart <= 1'b1;
        @(posedge clk);
        totalProgramStart <= 1'b0;
        sync();
        if (conv) begin
            sync();
        end
        $display("total done value=%h wired=%0b", v, wired);
    endtask : total

    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize

    initial begin
        logic [23:0] r;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        card(1'b1, 1'b0);
        total(24'h99_9287, 1'b1, 1'b1);
        // Back-to-back negative totals: each must convert once, no credit without entries
        for (int k = 0; k < 3; k++) begin
            r = 24'h90_0000;
            for (int i = 0; i < 5; i++) begin
                r[4*i +: 4] = 4'($unsigned($random(seed)) % 10);
            end
            total(r, 1'b1, 1'b0);
        end
        card(1'b0, 1'b1);
        total(24'h91_2345, 1'b0, 1'b0);
        total(24'h59_9999, 1'b1, 1'b0);
        repeat (4) @(posedge clk);
        if (notes.size() != 0) begin
            fails++;
            $display("Error at %0t: %0d results missing", $time, notes.size());
        end
        summarize();
    end

    initial begin
        #(20 * 20000);
        fails++;
        $display("Error at %0t: watchdog expired", $time);
        summarize();
    end
endmodule : ccs_sequencer_tb
